// >>> hw/peripheral_irq_flag_enable_bank.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "irq_bank_map.svh"

module peripheral_irq_flag_enable_bank (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire irq_bank_pkg::events_s events,
  input  wire irq_bank_pkg::modes_s  modes,
  input  wire irq_bank_pkg::prio_s   prio,
  input  wire logic [7:0]           flags_one,
  output logic                      irq_high_req,
  output logic                      irq_low_req
);
  import irq_bank_pkg::*;

  logic [7:0] flags_two_reg;
  logic [7:0] flags_three_reg;
  logic [7:0] enables_one_reg;
  logic [7:0] enables_two_reg;
  logic [7:0] enables_three_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] flags_two_next;
  logic [7:0] flags_three_next;
  logic [7:0] set_two;
  logic [7:0] set_three;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_en;
  logic       wr_lane;
  logic       setup;
  logic [7:0] act_one;
  logic [7:0] act_two;
  logic [7:0] act_three;
  logic       any_high;
  logic       any_low;
  logic       any_all;
  logic       group_en;
  logic       global_en;
  logic       prio_en;

  //////////////////////////////////////////////////////////////////////
  // Bus decode

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign wr_lane = pstrb[0];
  assign pready  = 1'b1;

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `OFS_FLAGS_TWO:     rd_byte = flags_two_reg & `MASK_TWO;
      `OFS_FLAGS_THREE:   rd_byte = flags_three_reg & `MASK_THREE;
      `OFS_ENABLES_ONE:   rd_byte = enables_one_reg & `MASK_ONE;
      `OFS_ENABLES_TWO:   rd_byte = enables_two_reg & `MASK_TWO;
      `OFS_ENABLES_THREE: rd_byte = enables_three_reg & `MASK_THREE;
      `OFS_IRQ_CTRL:      rd_byte = ctrl_reg & `MASK_CTRL;
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {24'h00_0000, rd_byte};
      pslverr <= ~rd_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event sets, independent of any enable

  always_comb begin
    set_two = 8'h00;
    set_two[`BIT_OSC_FAIL]    = events.osc_fail;
    set_two[`BIT_COMPARATOR]  = events.comparator_change;
    set_two[`BIT_BUS_COLL]    = events.bus_collision;
    set_two[`BIT_LOW_VOLT]    = events.low_voltage;
    set_two[`BIT_TIMER_THREE] = events.timer_three_overflow;
  end

  always_comb begin
    set_three = 8'h00;
    set_three[`BIT_DISPLAY] = events.display_frame_done
                            & modes.display_type_b
                            & ~modes.display_static;
    set_three[`BIT_CHARGE_TIME] = events.charge_time;
    set_three[`BIT_CAPCOMP_ONE] =
        (modes.capcomp_one_mode == CC_CAPTURE & events.capcomp_one_capture)
      | (modes.capcomp_one_mode == CC_COMPARE & events.capcomp_one_match);
    set_three[`BIT_CAPCOMP_TWO] =
        (modes.capcomp_two_mode == CC_CAPTURE & events.capcomp_two_capture)
      | (modes.capcomp_two_mode == CC_COMPARE & events.capcomp_two_match);
    set_three[`BIT_CALENDAR] = events.calendar_clock;
  end

  // Set wins over a clearing write in the same cycle
  always_comb begin
    flags_two_next = flags_two_reg;
    if (wr_en && wr_lane && paddr == `OFS_FLAGS_TWO) begin
      flags_two_next = pwdata[7:0];
    end
    flags_two_next = (flags_two_next | set_two) & `MASK_TWO;
  end

  always_comb begin
    flags_three_next = flags_three_reg;
    if (wr_en && wr_lane && paddr == `OFS_FLAGS_THREE) begin
      flags_three_next = (pwdata[7:0] & `MASK_THREE_RW)
                       | (flags_three_reg & ~`MASK_THREE_RW);
    end
    flags_three_next = (flags_three_next | set_three) & `MASK_THREE;
    flags_three_next[`BIT_SER_RX] = events.serial_two_rx_full;
    flags_three_next[`BIT_SER_TX] = events.serial_two_tx_empty;
  end

  //////////////////////////////////////////////////////////////////////
  // Flag registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_two_reg <= `RST_FLAGS;
    end else begin
      flags_two_reg <= flags_two_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_three_reg <= `RST_FLAGS;
    end else begin
      flags_three_reg <= flags_three_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Enable and control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_one_reg   <= `RST_ENABLES;
      enables_two_reg   <= `RST_ENABLES;
      enables_three_reg <= `RST_ENABLES;
    end else if (wr_en && wr_lane) begin
      case (paddr)
        `OFS_ENABLES_ONE:   enables_one_reg   <= pwdata[7:0] & `MASK_ONE;
        `OFS_ENABLES_TWO:   enables_two_reg   <= pwdata[7:0] & `MASK_TWO;
        `OFS_ENABLES_THREE: enables_three_reg <= pwdata[7:0] & `MASK_THREE;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RST_CTRL;
    end else if (wr_en && wr_lane && paddr == `OFS_IRQ_CTRL) begin
      ctrl_reg <= pwdata[7:0] & `MASK_CTRL;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Request generation

  assign group_en  = ctrl_reg[`BIT_GROUP_EN];
  assign global_en = ctrl_reg[`BIT_GLOBAL_EN];
  assign prio_en   = ctrl_reg[`BIT_PRIO_EN];

  assign act_one   = flags_one & enables_one_reg & `MASK_ONE;
  assign act_two   = flags_two_reg & enables_two_reg;
  assign act_three = flags_three_reg & enables_three_reg;

  assign any_all  = |{act_one, act_two, act_three};
  assign any_high = |{act_one & prio.prio_one, act_two & prio.prio_two,
                      act_three & prio.prio_three};
  assign any_low  = |{act_one & ~prio.prio_one, act_two & ~prio.prio_two,
                      act_three & ~prio.prio_three};

  // Two levels with priority on, one level otherwise
  always_comb begin
    if (prio_en) begin
      irq_high_req = global_en & any_high;
      irq_low_req  = global_en & group_en & any_low;
    end else begin
      irq_high_req = global_en & group_en & any_all;
      irq_low_req  = 1'b0;
    end
  end

endmodule

// >>> include/irq_bank_map.svh
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH

// Byte offsets on the register bus
`define OFS_FLAGS_TWO     12'h000
`define OFS_FLAGS_THREE   12'h004
`define OFS_ENABLES_ONE   12'h008
`define OFS_ENABLES_TWO   12'h00C
`define OFS_ENABLES_THREE 12'h010
`define OFS_IRQ_CTRL      12'h014

// Implemented bit masks
`define MASK_TWO          8'hCE
`define MASK_THREE        8'h7F
`define MASK_ONE          8'h7B
`define MASK_THREE_RW     8'h4F
`define MASK_CTRL         8'h07

// Reset values
`define RST_FLAGS         8'h00
`define RST_ENABLES       8'h00
`define RST_CTRL          8'h00

// Flag bit positions, register two
`define BIT_OSC_FAIL      7
`define BIT_COMPARATOR    6
`define BIT_BUS_COLL      3
`define BIT_LOW_VOLT      2
`define BIT_TIMER_THREE   1

// Flag bit positions, register three
`define BIT_DISPLAY       6
`define BIT_SER_RX        5
`define BIT_SER_TX        4
`define BIT_CHARGE_TIME   3
`define BIT_CAPCOMP_TWO   2
`define BIT_CAPCOMP_ONE   1
`define BIT_CALENDAR      0

// Control register bit positions
`define BIT_GROUP_EN      0
`define BIT_GLOBAL_EN     1
`define BIT_PRIO_EN       2
`endif

// >>> include/irq_bank_pkg.sv
package irq_bank_pkg;

  typedef enum logic [1:0] {
    CC_OFF     = 2'b00,
    CC_CAPTURE = 2'b01,
    CC_COMPARE = 2'b11,
    CC_PWM     = 2'b10
  } capcomp_mode_e;

  typedef struct packed {
    logic osc_fail;
    logic comparator_change;
    logic bus_collision;
    logic low_voltage;
    logic timer_three_overflow;
    logic display_frame_done;
    logic serial_two_rx_full;
    logic serial_two_tx_empty;
    logic charge_time;
    logic capcomp_one_capture;
    logic capcomp_one_match;
    logic capcomp_two_capture;
    logic capcomp_two_match;
    logic calendar_clock;
  } events_s;

  typedef struct packed {
    capcomp_mode_e capcomp_one_mode;
    capcomp_mode_e capcomp_two_mode;
    logic          display_type_b;
    logic          display_static;
  } modes_s;

  typedef struct packed {
    logic [7:0] prio_one;
    logic [7:0] prio_two;
    logic [7:0] prio_three;
  } prio_s;

endpackage

// >>> test/irq_bank_sva.sv
`timescale 1ns/1ps
module irq_bank_sva
  import irq_bank_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire irq_bank_pkg::events_s events,
  input wire logic                  irq_high_req,
  input wire logic                  irq_low_req
);
  logic live;
  wire  rd_two   = live && psel && !penable && paddr == 12'h000;
  wire  rd_three = live && psel && !penable && paddr == 12'h004;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // High once the previous edge was out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      live <= 1'b0;
    else
      live <= 1'b1;
  end

  ////////////////////////////////////////////////////////////
  property p_set_hi; rd_two |=> (prdata[7:6] | ~$past(events[13:12], 2)) == 2'b11; endproperty
  a_set_hi: assert property (p_set_hi) else $error("high flag missed");
  property p_set_lo; rd_two |=> (prdata[3:1] | ~$past(events[11:9], 2)) == 3'b111; endproperty
  a_set_lo: assert property (p_set_lo) else $error("low flag missed");
  property p_unimpl; rd_two |=> (prdata & 32'hFFFFFF31) == 32'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bit set");
  property p_rx; rd_three |=> prdata[5] == $past(events.serial_two_rx_full, 2); endproperty
  a_rx: assert property (p_rx) else $error("rx flag wrong");
  property p_tx; rd_three |=> prdata[4] == $past(events.serial_two_tx_empty, 2); endproperty
  a_tx: assert property (p_tx) else $error("tx flag wrong");
  property p_cal; rd_three |=> prdata[0] || !$past(events.calendar_clock, 2); endproperty
  a_cal: assert property (p_cal) else $error("calendar flag missed");
  property p_reset; $rose(presetn) |-> !irq_high_req && !irq_low_req && !pslverr; endproperty
  a_reset: assert property (p_reset) else $error("not clear after reset");
  property p_unmapped; psel && !penable && paddr > 12'h014 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
endmodule

bind peripheral_irq_flag_enable_bank irq_bank_sva u_irq_bank_sva (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr, .events, .irq_high_req,
  .irq_low_req
);

// >>> test/irq_sources.sv
`timescale 1ns/1ps
module irq_sources
  import irq_bank_pkg::*;
(
  input  wire logic            pclk,
  output irq_bank_pkg::events_s events,
  output irq_bank_pkg::modes_s  modes
);
  initial begin
    events = '0;
    modes  = '0;
  end

  // New event levels and modes from the next edge on
  task automatic drive(input logic [13:0] e, input logic [5:0] m);
    @(posedge pclk);
    events <= e;
    modes  <= m;
  endtask
endmodule

// >>> test/peripheral_irq_flag_enable_bank_tb.sv
`timescale 1ns/1ps
module peripheral_irq_flag_enable_bank_tb;
  import irq_bank_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        irq_high_req, irq_low_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  flags_one;
  events_s     events;
  modes_s      modes;
  prio_s       prio;
  int          bad_count, n_tests;

  peripheral_irq_flag_enable_bank u_peripheral_irq_flag_enable_bank (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .events, .modes, .prio, .flags_one, .irq_high_req, .irq_low_req
  );
  irq_sources u_irq_sources (.pclk, .events, .modes);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: no ready", $time);
      stop_test;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask

  task automatic irq(input logic [1:0] e);
    @(negedge pclk);
    chk({30'h0, irq_high_req, irq_low_req}, {30'h0, e});
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 24; a += 4) rdc(a[11:0], 32'h0);
    irq(2'b00);
    bus(12'h018, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_flags_two;
    u_irq_sources.drive(14'h3E00, 6'h00);
    u_irq_sources.drive(14'h0000, 6'h00);
    rdc(12'h000, 32'hCE);
    wr(12'h000, 8'h00);
    rdc(12'h000, 32'h00);
    wr(12'h000, 8'hFF);
    rdc(12'h000, 32'hCE);
    wr(12'h00C, 8'hFF);
    rdc(12'h00C, 32'hCE);
    wr(12'h010, 8'hFF);
    rdc(12'h010, 32'h7F);
    wr(12'h008, 8'hFF);
    rdc(12'h008, 32'h7B);
    $display("flag two test done");
  endtask

  task automatic t_gating;
    wr(12'h014, 8'h02);
    irq(2'b00);
    wr(12'h014, 8'h03);
    irq(2'b10);
    wr(12'h00C, 8'h00);
    irq(2'b00);
    @(posedge pclk);
    flags_one <= 8'h84;
    irq(2'b00);
    @(posedge pclk);
    flags_one <= 8'h40;
    irq(2'b10);
    @(posedge pclk);
    flags_one <= 8'h00;
    wr(12'h00C, 8'h02);
    prio <= 24'h000200;
    wr(12'h014, 8'h06);
    irq(2'b10);
    prio <= 24'h000000;
    irq(2'b00);
    wr(12'h014, 8'h07);
    irq(2'b01);
    wr(12'h014, 8'h00);
    wr(12'h000, 8'h00);
    $display("gating test done");
  endtask

  task automatic t_flags_three;
    u_irq_sources.drive(14'h0112, 6'h34);
    u_irq_sources.drive(14'h0000, 6'h34);
    rdc(12'h004, 32'h00);
    u_irq_sources.drive(14'h01B3, 6'h1E);
    u_irq_sources.drive(14'h0080, 6'h1E);
    rdc(12'h004, 32'h6F);
    wr(12'h004, 8'h00);
    rdc(12'h004, 32'h20);
    u_irq_sources.drive(14'h005E, 6'h28);
    u_irq_sources.drive(14'h0040, 6'h28);
    rdc(12'h004, 32'h10);
    u_irq_sources.drive(14'h0000, 6'h00);
    rdc(12'h004, 32'h00);
    $display("flag three test done");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    prio = '0;
    flags_one = 8'h00;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_flags_two;
    t_gating;
    t_flags_three;
    stop_test;
  end
endmodule
